/* hw/bca_alias_remap.sv */
`timescale 1ns/1ps
// What this block does
// - Back-channel CRC generated only while its enable bit is set; resets enabled.
// - Rate code 000 gives 2.5 Mbps, 001 gives 1.5625 Mbps; others reserved.
// - Serializer identifier auto-loads from the value received on the forward channel.
// - Freeze bit set stops auto-load; identifier keeps the software-written value.
// - Local address matching serializer alias is forwarded with physical address substituted.
// - Serializer alias of zero disables decoding of the remote serializer.
// - Serializer auto-acknowledge acknowledges every write to the serializer regardless.
// - Slot 0/1 alias matches are remapped to that slot's physical address.
// - Matched transactions forwarded while pass-through on match or pass-through of all traffic is enabled.
// - Global auto-acknowledge acknowledges all writes regardless of lock or remote ack.
module bca_alias_remap (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ident_rx_valid_i,
  input wire logic [6:0] ident_rx_i,
  input wire logic txn_start_i,
  input wire bca_pkg::bca_hdr_t txn_hdr_i,
  input wire bca_pkg::bca_byte_t txn_byte_i,
  input wire logic txn_stop_i,
  output bca_pkg::bca_hdr_t fwd_hdr_o,
  output logic fwd_start_o,
  output bca_pkg::bca_byte_t fwd_byte_o,
  output logic fwd_stop_o,
  output logic local_ack_o,
  output logic crc_gen_on_o,
  output logic [2:0] return_link_rate_sel_o,
  output logic rate_slow_o,
  output logic back_channel_on_o
);
  import bca_pkg::*;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] setup_reg, setup_next;
  logic [7:0] rsvd_a_reg, rsvd_a_next;
  logic [7:0] rsvd_b_reg, rsvd_b_next;
  logic [7:0] ident_reg, ident_next;
  logic [7:0] ser_alias_reg, ser_alias_next;
  logic [7:0] slv_phys_reg [BCA_NUM_SLOTS];
  logic [7:0] slv_phys_next [BCA_NUM_SLOTS];
  logic [7:0] slv_alias_reg [BCA_NUM_SLOTS];
  logic [7:0] slv_alias_next [BCA_NUM_SLOTS];
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    setup_next = setup_reg;
    rsvd_a_next = rsvd_a_reg;
    rsvd_b_next = rsvd_b_reg;
    ident_next = ident_reg;
    ser_alias_next = ser_alias_reg;
    if (reg_we_i) begin
      unique case (reg_addr_i)
        BCA_OFS_SETUP: begin
          setup_next[7:BCA_BIT_CRC_GEN] = reg_wdata_i[7:BCA_BIT_CRC_GEN];
          // Reserved rate codes are ignored, rate field holds
          if (reg_wdata_i[BCA_RATE_MSB:0] == BCA_RATE_2M5 ||
              reg_wdata_i[BCA_RATE_MSB:0] == BCA_RATE_1M5625) begin
            setup_next[BCA_RATE_MSB:0] = reg_wdata_i[BCA_RATE_MSB:0];
          end
        end
        BCA_OFS_RSVD_A: rsvd_a_next = reg_wdata_i;
        BCA_OFS_RSVD_B: rsvd_b_next = reg_wdata_i;
        BCA_OFS_IDENT: ident_next = reg_wdata_i;
        BCA_OFS_SER_ALIAS: ser_alias_next = reg_wdata_i;
        default: ;
      endcase
    end
    // Hardware load wins over a software write in the same cycle unless the write sets bit 0
    if (ident_rx_valid_i && !ident_next[BCA_BIT_LOW]) begin
      ident_next[7:1] = ident_rx_i;
    end
  end

  generate
    for (genvar s = 0; s < BCA_NUM_SLOTS; s++) begin : g_slot
      localparam logic [7:0] PHYS_OFS = BCA_OFS_SLV0_PHYS + 8'(s);
      localparam logic [7:0] ALIAS_OFS = BCA_OFS_SLV0_ALIAS + 8'(s);
      always_comb begin
        slv_phys_next[s] = slv_phys_reg[s];
        slv_alias_next[s] = slv_alias_reg[s];
        // Reserved bit 0 always reads zero
        if (reg_we_i && reg_addr_i == PHYS_OFS) begin
          slv_phys_next[s] = {reg_wdata_i[7:1], 1'b0};
        end
        if (reg_we_i && reg_addr_i == ALIAS_OFS) begin
          slv_alias_next[s] = reg_wdata_i;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          slv_phys_reg[s] <= BCA_RST_ZERO;
          slv_alias_reg[s] <= BCA_RST_ZERO;
        end else if (ce_i) begin
          slv_phys_reg[s] <= slv_phys_next[s];
          slv_alias_reg[s] <= slv_alias_next[s];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Read pipeline
  // ************************************************************
  always_comb begin
    rdata_next = BCA_RST_ZERO;
    unique case (reg_addr_i)
      BCA_OFS_SETUP: rdata_next = setup_reg;
      BCA_OFS_RSVD_A: rdata_next = rsvd_a_reg;
      BCA_OFS_RSVD_B: rdata_next = rsvd_b_reg;
      BCA_OFS_IDENT: rdata_next = ident_reg;
      BCA_OFS_SER_ALIAS: rdata_next = ser_alias_reg;
      BCA_OFS_SLV0_PHYS: rdata_next = slv_phys_reg[0];
      BCA_OFS_SLV1_PHYS: rdata_next = slv_phys_reg[1];
      BCA_OFS_SLV0_ALIAS: rdata_next = slv_alias_reg[0];
      BCA_OFS_SLV1_ALIAS: rdata_next = slv_alias_reg[1];
      default: rdata_next = BCA_RST_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      setup_reg <= BCA_RST_SETUP;
      rsvd_a_reg <= BCA_RST_ZERO;
      rsvd_b_reg <= BCA_RST_ZERO;
      ident_reg <= BCA_RST_ZERO;
      ser_alias_reg <= BCA_RST_ZERO;
      rdata_reg <= BCA_RST_ZERO;
    end else if (ce_i) begin
      setup_reg <= setup_next;
      rsvd_a_reg <= rsvd_a_next;
      rsvd_b_reg <= rsvd_b_next;
      ident_reg <= ident_next;
      ser_alias_reg <= ser_alias_next;
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Back-channel configuration outputs
  // ************************************************************
  logic crc_reg, crc_next;
  logic [2:0] rate_reg, rate_next;
  logic slow_reg, slow_next;
  logic bc_on_reg, bc_on_next;

  always_comb begin
    // Outputs lag setup register by one cycle
    crc_next = setup_reg[BCA_BIT_CRC_GEN];
    rate_next = setup_reg[BCA_RATE_MSB:0];
    slow_next = (setup_reg[BCA_RATE_MSB:0] == BCA_RATE_1M5625);
    // Forced on or any pass-through enabled
    bc_on_next = setup_reg[BCA_BIT_ALWAYS_ON]
                 | setup_reg[BCA_BIT_PASS_MATCH]
                 | setup_reg[BCA_BIT_PASS_ALL];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      crc_reg <= BCA_RST_SETUP[BCA_BIT_CRC_GEN];
      rate_reg <= BCA_RATE_2M5;
      slow_reg <= 1'b0;
      bc_on_reg <= BCA_RST_SETUP[BCA_BIT_ALWAYS_ON];
    end else if (ce_i) begin
      crc_reg <= crc_next;
      rate_reg <= rate_next;
      slow_reg <= slow_next;
      bc_on_reg <= bc_on_next;
    end
  end

  // ************************************************************
  // Address decode and remap
  // ************************************************************
  logic ser_hit;
  logic [BCA_NUM_SLOTS-1:0] slot_hit;
  logic [BCA_NUM_SLOTS-1:0] slot_ack;
  logic [6:0] remap_addr;

  generate
    for (genvar s = 0; s < BCA_NUM_SLOTS; s++) begin : g_hit
      assign slot_hit[s] = (slv_alias_reg[s][7:1] != 7'h00)
                           && (txn_hdr_i.addr == slv_alias_reg[s][7:1]);
      assign slot_ack[s] = slot_hit[s] && slv_alias_reg[s][BCA_BIT_LOW];
    end
  endgenerate

  // Zero alias never matches, remote access off
  assign ser_hit = (ser_alias_reg[7:1] != 7'h00) && (txn_hdr_i.addr == ser_alias_reg[7:1]);

  always_comb begin
    remap_addr = txn_hdr_i.addr;
    // Serializer alias wins over slot aliases
    if (ser_hit) begin
      remap_addr = ident_reg[7:1];
    end else if (slot_hit[0]) begin
      remap_addr = slv_phys_reg[0][7:1];
    end else if (slot_hit[1]) begin
      remap_addr = slv_phys_reg[1][7:1];
    end
  end

  // ************************************************************
  // Transaction sequencer
  // ************************************************************
  bca_state_t state_reg, state_next;
  bca_hdr_t hdr_reg, hdr_next;
  logic start_reg, start_next;
  bca_byte_t byte_reg, byte_next;
  logic stop_reg, stop_next;
  logic ack_reg, ack_next;
  logic any_hit;
  logic fwd_ok;

  assign any_hit = ser_hit | (|slot_hit);
  assign fwd_ok = (any_hit && setup_reg[BCA_BIT_PASS_MATCH])
                  || setup_reg[BCA_BIT_PASS_ALL];

  always_comb begin
    state_next = state_reg;
    hdr_next = hdr_reg;
    start_next = 1'b0;
    byte_next = '0;
    stop_next = 1'b0;
    ack_next = ack_reg;
    // Start overrides any open transaction
    if (txn_start_i) begin
      // Acknowledge decided once, writes only
      ack_next = !txn_hdr_i.rw && (setup_reg[BCA_BIT_ACK_ALL]
                 || (ser_hit && ser_alias_reg[BCA_BIT_LOW])
                 || (|slot_ack));
      if (fwd_ok) begin
        state_next = BCA_FWD;
        hdr_next.addr = remap_addr;
        hdr_next.rw = txn_hdr_i.rw;
        start_next = 1'b1;
      end else begin
        state_next = BCA_DROP;
      end
    end else begin
      unique case (state_reg)
        BCA_IDLE: ;
        BCA_FWD: begin
          byte_next = txn_byte_i;
          if (txn_stop_i) begin
            stop_next = 1'b1;
            state_next = BCA_IDLE;
            ack_next = 1'b0;
          end
        end
        // Traffic not forwarded is swallowed up to stop
        BCA_DROP: begin
          if (txn_stop_i) begin
            state_next = BCA_IDLE;
            ack_next = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= BCA_IDLE;
      hdr_reg <= '0;
      start_reg <= 1'b0;
      byte_reg <= '0;
      stop_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      hdr_reg <= hdr_next;
      start_reg <= start_next;
      byte_reg <= byte_next;
      stop_reg <= stop_next;
      ack_reg <= ack_next;
    end
  end

  // ************************************************************
  // Output ports
  // ************************************************************
  assign reg_rdata_o = rdata_reg;
  assign fwd_hdr_o = hdr_reg;
  assign fwd_start_o = start_reg;
  assign fwd_byte_o = byte_reg;
  assign fwd_stop_o = stop_reg;
  assign local_ack_o = ack_reg;
  assign crc_gen_on_o = crc_reg;
  assign return_link_rate_sel_o = rate_reg;
  assign rate_slow_o = slow_reg;
  assign back_channel_on_o = bc_on_reg;

endmodule // bca_alias_remap

/* hw/bca_pkg.sv */
package bca_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] BCA_OFS_SETUP = 8'h58;
  localparam logic [7:0] BCA_OFS_RSVD_A = 8'h59;
  localparam logic [7:0] BCA_OFS_RSVD_B = 8'h5a;
  localparam logic [7:0] BCA_OFS_IDENT = 8'h5b;
  localparam logic [7:0] BCA_OFS_SER_ALIAS = 8'h5c;
  localparam logic [7:0] BCA_OFS_SLV0_PHYS = 8'h5d;
  localparam logic [7:0] BCA_OFS_SLV1_PHYS = 8'h5e;
  localparam logic [7:0] BCA_OFS_SLV0_ALIAS = 8'h65;
  localparam logic [7:0] BCA_OFS_SLV1_ALIAS = 8'h66;

  // ************************************************************
  // Field positions of the setup register, and bit 0 of the identifier and alias registers
  // ************************************************************
  localparam int BCA_BIT_PASS_ALL = 7;
  localparam int BCA_BIT_PASS_MATCH = 6;
  localparam int BCA_BIT_ACK_ALL = 5;
  localparam int BCA_BIT_ALWAYS_ON = 4;
  localparam int BCA_BIT_CRC_GEN = 3;
  localparam int BCA_RATE_MSB = 2;
  localparam int BCA_BIT_LOW = 0;

  // ************************************************************
  // Reset values, rate codes and slot count
  // ************************************************************
  localparam logic [7:0] BCA_RST_SETUP = 8'h18;
  localparam logic [7:0] BCA_RST_ZERO = 8'h00;
  localparam logic [2:0] BCA_RATE_2M5 = 3'h0;
  localparam logic [2:0] BCA_RATE_1M5625 = 3'h1;
  localparam int BCA_NUM_SLOTS = 2;

  typedef struct packed {
    logic [6:0] addr;
    logic rw;
  } bca_hdr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bca_byte_t;

  typedef enum logic [2:0] {
    BCA_IDLE = 3'h1,
    BCA_FWD = 3'h2,
    BCA_DROP = 3'h4
  } bca_state_t;

endpackage

/* test/bca_alias_remap_monitor.sv */
`timescale 1ns/1ps
module bca_alias_remap_monitor
  import bca_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic txn_start_i,
  input wire bca_pkg::bca_hdr_t txn_hdr_i,
  input wire bca_pkg::bca_byte_t txn_byte_i,
  input wire logic txn_stop_i,
  input wire bca_pkg::bca_hdr_t fwd_hdr_o,
  input wire logic fwd_start_o,
  input wire bca_pkg::bca_byte_t fwd_byte_o,
  input wire logic fwd_stop_o,
  input wire logic local_ack_o,
  input wire logic crc_gen_on_o,
  input wire logic [2:0] return_link_rate_sel_o,
  input wire logic rate_slow_o
);
  // ********************
  // Port checks
  // ********************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic su_wr;
  assign su_wr = ce_i && reg_we_i && (reg_addr_i == BCA_OFS_SETUP);
  chk_crc_follow: assert property (
    su_wr |-> ##2 crc_gen_on_o == $past(reg_wdata_i[BCA_BIT_CRC_GEN], 2)) else $error("crc enable wrong");
  chk_rate_legal: assert property (
    su_wr && reg_wdata_i[2:1] == 2'h0 |-> ##2 return_link_rate_sel_o == $past(reg_wdata_i[2:0], 2)
    && rate_slow_o == $past(reg_wdata_i[0], 2)) else $error("rate code wrong");
  chk_rate_keep: assert property (
    su_wr && reg_wdata_i[2:1] != 2'h0 |-> ##2 return_link_rate_sel_o == $past(return_link_rate_sel_o, 1))
    else $error("reserved rate taken");
  chk_start_cause: assert property (
    fwd_start_o |-> $past(txn_start_i && ce_i)) else $error("forward without start");
  chk_rw_keep: assert property (
    fwd_start_o |-> fwd_hdr_o.rw == $past(txn_hdr_i.rw)) else $error("rw bit altered");
  chk_byte_pass: assert property (
    fwd_byte_o.valid |-> fwd_byte_o == $past(txn_byte_i)) else $error("data byte altered");
  chk_stop_cause: assert property (
    fwd_stop_o |-> $past(txn_stop_i)) else $error("stop without cause");
  chk_ack_clear: assert property (
    ce_i && txn_stop_i && !txn_start_i |=> !local_ack_o) else $error("ack not cleared");
  chk_ack_read: assert property (
    ce_i && txn_start_i && txn_hdr_i.rw |=> !local_ack_o) else $error("read acknowledged");
endmodule // bca_alias_remap_monitor
bind bca_alias_remap bca_alias_remap_monitor u_mon (.sys_clk_i, .rst_n_i, .ce_i, .reg_addr_i,
  .reg_wdata_i, .reg_we_i, .txn_start_i, .txn_hdr_i, .txn_byte_i, .txn_stop_i, .fwd_hdr_o,
  .fwd_start_o, .fwd_byte_o, .fwd_stop_o, .local_ack_o, .crc_gen_on_o, .return_link_rate_sel_o,
  .rate_slow_o);

/* test/bca_ser_model.sv */
`timescale 1ns/1ps
module bca_ser_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [6:0] id_i,
  output logic id_valid_o,
  output logic [6:0] id_o
);
  // ********************
  // Identifier sender
  // ********************
  initial id_valid_o = 1'b0;
  initial id_o = 7'h00;
  always @(posedge clk_i) begin
    id_valid_o <= send_i;
    id_o <= send_i ? id_i : ~id_o;
  end
endmodule // bca_ser_model

/* test/tb_bca_alias_remap.sv */
`timescale 1ns/1ps
module tb_bca_alias_remap;
  import bca_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, we = 1'b0, start = 1'b0, stop = 1'b0, send = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [6:0] sid = 7'h00, rx_id;
  logic rx_v, fstart, fstop, ack, crc, slow, bcon;
  logic [2:0] rate;
  bca_hdr_t hdr = '0, fhdr;
  bca_byte_t tbyte = '0, fbyte;
  int mismatches = 0, total_checks = 0, cycles = 0;
  // ********************
  // Harness
  // ********************
  always #20 clk = ~clk;
  bca_ser_model u_ser (.clk_i(clk), .send_i(send), .id_i(sid), .id_valid_o(rx_v), .id_o(rx_id));
  bca_alias_remap DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_rdata_o(rdata), .ident_rx_valid_i(rx_v),
    .ident_rx_i(rx_id), .txn_start_i(start), .txn_hdr_i(hdr), .txn_byte_i(tbyte),
    .txn_stop_i(stop), .fwd_hdr_o(fhdr), .fwd_start_o(fstart), .fwd_byte_o(fbyte),
    .fwd_stop_o(fstop), .local_ack_o(ack), .crc_gen_on_o(crc), .return_link_rate_sel_o(rate),
    .rate_slow_o(slow), .back_channel_on_o(bcon));
  task results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("ERROR %0t: timeout", $time);
      results;
    end
  end
  task chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk({1'b0, rdata}, {1'b0, e});
  endtask
  task ser(input logic [6:0] id);
    @(posedge clk);
    sid <= id;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
  endtask
  task txn(input logic [6:0] a, input logic rw, input logic fw, input logic [6:0] fa, input logic ak);
    @(posedge clk);
    start <= 1'b1;
    hdr <= '{a, rw};
    @(posedge clk);
    start <= 1'b0;
    tbyte <= '{1'b1, 8'h5a};
    @(negedge clk);
    chk(fstart, fw);
    if (fw) chk(fhdr, {fa, rw});
    chk(ack, ak);
    @(posedge clk);
    tbyte <= '0;
    stop <= 1'b1;
    @(negedge clk);
    chk(fbyte, fw ? 9'h15a : 9'h000);
    @(posedge clk);
    stop <= 1'b0;
    @(negedge clk);
    chk(fstop, fw);
    chk(ack, 1'b0);
  endtask
  // ********************
  // Scenarios
  // ********************
  task t_reset;
    rd(BCA_OFS_SETUP, BCA_RST_SETUP);
    for (int i = 8'h59; i <= 8'h5e; i++) rd(i[7:0], 8'h00);
    rd(8'h70, 8'h00);
    chk(crc, 1'b1);
    chk(rate, 3'h0);
  endtask
  task t_setup;
    wr(BCA_OFS_SETUP, 8'h38);
    wr(BCA_OFS_SETUP, 8'h31);
    rd(BCA_OFS_SETUP, 8'h31);
    chk({slow, rate}, 4'h9);
    for (int c = 2; c < 8; c++) begin
      wr(BCA_OFS_SETUP, 8'h10 | c[7:0]);
      rd(BCA_OFS_SETUP, 8'h11);
    end
    wr(BCA_OFS_SETUP, 8'h00);
    rd(BCA_OFS_SETUP, 8'h00);
    chk({crc, bcon, slow, rate}, 6'h00);
    wr(BCA_OFS_SETUP, 8'h18);
    rd(BCA_OFS_SETUP, 8'h18);
    chk({crc, bcon, slow, rate}, 6'h30);
  endtask
  task t_hold;
    @(posedge clk);
    ce <= 1'b0;
    wr(BCA_OFS_SETUP, 8'h21);
    @(posedge clk);
    ce <= 1'b1;
    rd(BCA_OFS_SETUP, 8'h18);
    chk({crc, bcon, slow, rate}, 6'h30);
  endtask
  task t_ident;
    ser(7'h2a);
    rd(BCA_OFS_IDENT, 8'h54);
    wr(BCA_OFS_IDENT, 8'h33);
    ser(7'h55);
    rd(BCA_OFS_IDENT, 8'h33);
  endtask
  task t_slot;
    wr(BCA_OFS_SLV0_PHYS, 8'ha1);
    rd(BCA_OFS_SLV0_PHYS, 8'ha0);
    wr(BCA_OFS_SLV1_PHYS, 8'h7c);
    wr(BCA_OFS_SLV0_ALIAS, 8'h40);
    wr(BCA_OFS_SLV1_ALIAS, 8'h63);
    wr(BCA_OFS_SETUP, 8'h58);
    txn(7'h20, 1'b1, 1'b1, 7'h50, 1'b0);
    txn(7'h31, 1'b0, 1'b1, 7'h3e, 1'b1);
    wr(BCA_OFS_SETUP, 8'h18);
    txn(7'h20, 1'b0, 1'b0, 7'h00, 1'b0);
  endtask
  task t_ser;
    wr(BCA_OFS_SETUP, 8'h58);
    wr(BCA_OFS_SER_ALIAS, 8'h47);
    txn(7'h23, 1'b0, 1'b1, 7'h19, 1'b1);
    txn(7'h23, 1'b1, 1'b1, 7'h19, 1'b0);
    wr(BCA_OFS_SER_ALIAS, 8'h01);
    txn(7'h00, 1'b0, 1'b0, 7'h00, 1'b0);
    wr(BCA_OFS_SETUP, 8'h38);
    txn(7'h11, 1'b0, 1'b0, 7'h00, 1'b1);
    wr(BCA_OFS_SETUP, 8'h98);
    txn(7'h11, 1'b1, 1'b1, 7'h11, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_setup;
    t_hold;
    t_ident;
    t_slot;
    t_ser;
    results;
  end
endmodule // tb_bca_alias_remap
